//--- logic/upmi_port.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - one shared pin group, one variant active
// - frames carry preamble, delimiter, headers, payload, CRC
// - MII runs at 10 or 100 Mbps
// - MII uses four-bit data and error lines
// - MII gives carrier and collision status
// - MII half and full duplex; collision half only
// - RMII 10/100 timed by one 50 MHz reference
// - RMII clock mode drives reference on rx clock
// - RMII uses two-bit data and CRS_DV
// - RGMII muxes control, uses both clock edges; both only at gigabit here
// - gigabit RGMII latches data on both edges
// - device drives RGMII rx clock, control, data
// - RGMII carries up to 1000 Mbps; gigabit clock only 50 MHz here
// - control bits 4 and 3 set clock delays
// - mode from strap or bits 1:0, 11 RGMII
// - bit 6 selects gigabit or 10/100 speed
// - bit 7 selects RMII clock mode
// - MII PHY side or MAC side by strap
// - nibble path at quarter bit rate, unencoded
module upmi_port (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] uplink_pad_drive,
  input  wire logic [1:0] interface_select_strap,
  input  wire logic       speed_select_strap,
  input  wire logic       clock_or_phy_mode_strap,
  input  wire logic       half_duplex,
  input  wire logic       uplink_tx_clock_in,
  output logic            uplink_tx_clock_out,
  output logic            uplink_tx_clock_oe,
  input  wire logic       uplink_tx_control_in,
  input  wire logic       uplink_tx_err_in,
  input  wire logic [3:0] uplink_tx_data_in,
  input  wire logic       uplink_rx_clock_in,
  output logic            uplink_rx_clock_out,
  output logic            uplink_rx_clock_oe,
  output logic            uplink_rx_control_out,
  output logic            uplink_rx_err_out,
  output logic      [3:0] uplink_rx_data_out,
  input  wire logic       collision_in,
  output logic            collision_out,
  output logic            collision_oe,
  input  wire logic       carrier_in,
  output logic            carrier_out,
  output logic            carrier_oe,
  output logic      [7:0] ing_data,
  output logic            ing_valid,
  output logic            ing_sof,
  output logic            ing_err,
  input  wire logic [7:0] egr_data,
  input  wire logic       egr_last,
  input  wire logic       egr_valid,
  output logic            egr_ready
);
  import upmi_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic [PIN_W-1:0] pin_s1_ff, pin_s2_ff;
  logic             txc_d_ff, rxc_d_ff;
  logic [1:0]       strap_cnt_ff;
  logic [7:0]       ctrl_ff, pad_ff, rdata_ff;
  logic             mii_phy_ff;
  logic [4:0]       div_cnt_ff, half;
  logic             div_clk_ff, dclk_d_ff;
  logic [3:0]       dec_cnt_ff;
  logic             txclk_ff, txoe_ff, rxclk_ff, rxoe_ff;
  logic             col_ff, crs_ff, stat_oe_ff;
  logic             ing_stb_d_ff, rise_d_ff, en_ff, in_frame_ff, err_acc_ff;
  logic [1:0]       ucnt_in_ff, ucnt_out_ff, upb;
  logic [7:0]       acc_ff, nxt_acc, ing_data_ff, byte_ff, sel;
  logic             ing_valid_ff, ing_sof_ff, ing_err_ff;
  upmi_egr_t        egr_state_ff;
  logic [2:0]       pre_cnt_ff;
  logic             last_ff, rx_ctl_ff, rx_err_ff;
  logic [3:0]       rx_dat_ff;
  logic             txc_s, rxc_s, tctl, terr, col_s, crs_s, hdx, strap_spd, strap_clk;
  logic [3:0]       tdat;
  logic [1:0]       strap_if;
  logic             strap_load, ctrl_wr, txin_rise, txin_fall, rxin_rise, tick, own_rise, own_fall;
  upmi_if_t         if_mode;
  logic             is_mii, is_rmii, is_rgmii, gbit, rmii_clk, dly_ing, dly_egr, ddr_mode;
  logic             rmii_tick, ing_stb, egr_stb, ing_take, take_rise, cur_en, cur_err;
  logic             byte_end, start_ok, fifo_pop, f_valid, f_last;
  logic [7:0]       f_data;

  // two-stage synchronisers for every pin and strap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      txc_d_ff  <= 1'b0;
      rxc_d_ff  <= 1'b0;
    end else begin
      pin_s1_ff <= {uplink_tx_clock_in, uplink_rx_clock_in, uplink_tx_control_in, uplink_tx_err_in,
                    uplink_tx_data_in, collision_in, carrier_in, interface_select_strap,
                    speed_select_strap, clock_or_phy_mode_strap, half_duplex};
      pin_s2_ff <= pin_s1_ff;
      txc_d_ff  <= pin_s2_ff[14];
      rxc_d_ff  <= pin_s2_ff[13];
    end
  end

  assign {txc_s, rxc_s, tctl, terr, tdat, col_s, crs_s, strap_if, strap_spd, strap_clk, hdx} = pin_s2_ff;
  assign txin_rise = txc_s && !txc_d_ff;
  assign txin_fall = !txc_s && txc_d_ff;
  assign rxin_rise = rxc_s && !rxc_d_ff;

  // configuration registers
  assign strap_load = strap_cnt_ff == STRAP_LOAD_AT;
  assign ctrl_wr    = reg_wr_en && (reg_addr == CTRL_ADDR);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_cnt_ff <= '0;
      ctrl_ff      <= CTRL_RST;
      mii_phy_ff   <= 1'b0;
    end else begin
      if (strap_cnt_ff != 2'h3) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
      if (strap_load) begin
        mii_phy_ff <= strap_clk;
      end
      if (ctrl_wr) begin
        ctrl_ff <= reg_wdata & CTRL_WMASK;
      end else if (strap_load) begin
        ctrl_ff <= {strap_clk, strap_spd, ctrl_ff[5:2], strap_if};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pad_ff   <= PAD_RST;
      rdata_ff <= '0;
    end else begin
      if (reg_wr_en && (reg_addr == PAD_ADDR)) begin
        pad_ff <= reg_wdata;
      end
      if (reg_rd_en) begin
        rdata_ff <= (reg_addr == CTRL_ADDR) ? ctrl_ff : (reg_addr == PAD_ADDR) ? pad_ff : 8'h00;
      end
    end
  end

  assign reg_rdata        = rdata_ff;
  assign uplink_pad_drive = pad_ff;

  assign if_mode  = upmi_if_t'(ctrl_ff[IF_SEL_LSB +: 2]);
  assign is_mii   = if_mode == IF_MII;
  assign is_rmii  = if_mode == IF_RMII;
  assign is_rgmii = if_mode == IF_RGMII;
  assign gbit     = ctrl_ff[SPEED_BIT];
  assign rmii_clk = ctrl_ff[RMII_CLK_BIT];
  assign dly_ing  = ctrl_ff[ING_DLY_BIT];
  assign dly_egr  = ctrl_ff[EGR_DLY_BIT];
  assign ddr_mode = is_rgmii && gbit;
  assign upb      = is_rmii ? UNITS_DIBIT : UNITS_NIBBLE;

  // own link clock divider
  always_comb begin
    if (is_rmii) begin
      half = HALF_RMII;
    end else if (ddr_mode) begin
      half = HALF_RGMII;
    end else begin
      half = gbit ? HALF_MII_FAST : HALF_MII_SLOW;
    end
  end

  assign tick     = div_cnt_ff >= half - 5'h01;
  assign own_rise = tick && !div_clk_ff;
  assign own_fall = tick && div_clk_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_cnt_ff <= '0;
      div_clk_ff <= 1'b0;
      dec_cnt_ff <= '0;
    end else begin
      div_cnt_ff <= tick ? 5'h00 : div_cnt_ff + 5'h01;
      if (tick) begin
        div_clk_ff <= !div_clk_ff;
      end
      if (rmii_tick || (is_rmii && !gbit && (rmii_clk ? own_rise : txin_rise))) begin
        dec_cnt_ff <= (dec_cnt_ff == RMII_SLOW_DIV) ? 4'h0 : dec_cnt_ff + 4'h1;
      end
    end
  end

  // one reference edge in ten carries data at 10 mbps
  assign rmii_tick = (rmii_clk ? own_rise : txin_rise) && (gbit || dec_cnt_ff == 4'h0);

  always_comb begin
    ing_stb = 1'b0;
    egr_stb = 1'b0;
    unique case (if_mode)
      IF_RGMII: begin
        ing_stb = gbit ? (txin_rise || txin_fall) : txin_rise;
        egr_stb = gbit ? (own_rise || own_fall) : own_rise;
      end
      IF_RMII: begin
        ing_stb = rmii_tick;
        egr_stb = rmii_tick;
      end
      IF_MII: begin
        ing_stb = mii_phy_ff ? own_rise : txin_rise;
        egr_stb = mii_phy_ff ? own_rise : rxin_rise;
      end
      IF_RSVD: begin
      end
    endcase
  end

  // ingress capture with optional clock delay
  assign ing_take  = (is_rgmii && dly_ing) ? ing_stb_d_ff : ing_stb;
  assign take_rise = (is_rgmii && dly_ing) ? rise_d_ff : txin_rise;

  always_comb begin
    cur_en  = tctl;
    cur_err = 1'b0;
    nxt_acc = is_rmii ? {tdat[1:0], acc_ff[7:2]} : {tdat, acc_ff[7:4]};
    if (ddr_mode) begin
      cur_en  = take_rise ? tctl : en_ff;
      cur_err = !take_rise && (tctl ^ en_ff);
    end else if (is_mii) begin
      cur_err = terr;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ing_stb_d_ff <= 1'b0;
      rise_d_ff    <= 1'b0;
      en_ff        <= 1'b0;
      in_frame_ff  <= 1'b0;
      err_acc_ff   <= 1'b0;
      ucnt_in_ff   <= '0;
      acc_ff       <= '0;
      ing_data_ff  <= '0;
      ing_valid_ff <= 1'b0;
      ing_sof_ff   <= 1'b0;
      ing_err_ff   <= 1'b0;
    end else begin
      ing_stb_d_ff <= ing_stb;
      rise_d_ff    <= txin_rise;
      ing_valid_ff <= 1'b0;
      if (ing_take) begin
        if (take_rise || !ddr_mode) begin
          en_ff <= tctl;
        end
        if (cur_en) begin
          acc_ff     <= nxt_acc;
          err_acc_ff <= err_acc_ff || cur_err;
          if (ucnt_in_ff == upb) begin
            ucnt_in_ff   <= '0;
            ing_valid_ff <= 1'b1;
            ing_data_ff  <= nxt_acc;
            ing_err_ff   <= err_acc_ff || cur_err;
            ing_sof_ff   <= !in_frame_ff;
            in_frame_ff  <= 1'b1;
            err_acc_ff   <= 1'b0;
          end else begin
            ucnt_in_ff <= ucnt_in_ff + 2'h1;
          end
        end else begin
          ucnt_in_ff  <= '0;
          in_frame_ff <= 1'b0;
          err_acc_ff  <= 1'b0;
        end
      end
    end
  end

  assign ing_data  = ing_data_ff;
  assign ing_valid = ing_valid_ff;
  assign ing_sof   = ing_sof_ff;
  assign ing_err   = ing_err_ff;

  upmi_fifo #(
    .WIDTH(9),
    .DEPTH(2)
  ) u_egr_buf (
    .clock    (clock),
    .rst      (rst),
    .in_data  ({egr_last, egr_data}),
    .in_valid (egr_valid),
    .in_ready (egr_ready),
    .out_data ({f_last, f_data}),
    .out_valid(f_valid),
    .out_ready(fifo_pop)
  );

  // egress: preamble and delimiter, then buffered bytes
  assign byte_end = ucnt_out_ff == upb;
  assign start_ok = f_valid && !(is_mii && !mii_phy_ff && hdx && crs_s) && (!ddr_mode || own_rise);
  assign fifo_pop = egr_stb && byte_end && f_valid &&
                    (((egr_state_ff == E_PRE) && (pre_cnt_ff == PRE_END_IDX)) ||
                     ((egr_state_ff == E_DATA) && !last_ff));
  assign sel      = is_rmii ? byte_ff >> {ucnt_out_ff, 1'b0} : byte_ff >> {ucnt_out_ff[0], 2'b00};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      egr_state_ff <= E_IDLE;
      pre_cnt_ff   <= '0;
      ucnt_out_ff  <= '0;
      byte_ff      <= '0;
      last_ff      <= 1'b0;
      rx_ctl_ff    <= 1'b0;
      rx_err_ff    <= 1'b0;
      rx_dat_ff    <= '0;
    end else if (if_mode == IF_RSVD) begin
      egr_state_ff <= E_IDLE;
      rx_ctl_ff    <= 1'b0;
      rx_err_ff    <= 1'b0;
      rx_dat_ff    <= '0;
    end else if (egr_stb) begin
      unique case (egr_state_ff)
        E_IDLE: begin
          rx_ctl_ff <= 1'b0;
          rx_err_ff <= 1'b0;
          rx_dat_ff <= '0;
          if (start_ok) begin
            egr_state_ff <= E_PRE;
            byte_ff      <= PREAMBLE_BYTE;
            pre_cnt_ff   <= '0;
            ucnt_out_ff  <= '0;
          end
        end
        E_PRE, E_DATA: begin
          rx_ctl_ff <= 1'b1;
          rx_err_ff <= 1'b0;
          rx_dat_ff <= is_rmii ? {2'b00, sel[1:0]} : sel[3:0];
          ucnt_out_ff <= byte_end ? 2'h0 : ucnt_out_ff + 2'h1;
          if (byte_end && egr_state_ff == E_PRE) begin
            pre_cnt_ff <= pre_cnt_ff + 3'h1;
            if (pre_cnt_ff == PRE_END_IDX) begin
              egr_state_ff <= E_DATA;
              byte_ff      <= f_data;
              last_ff      <= f_last;
            end else begin
              byte_ff <= (pre_cnt_ff == PRE_SFD_IDX) ? SFD_BYTE : PREAMBLE_BYTE;
            end
          end else if (byte_end) begin
            if (last_ff) begin
              egr_state_ff <= E_IDLE;
            end else if (f_valid) begin
              byte_ff <= f_data;
              last_ff <= f_last;
            end else begin
              rx_err_ff    <= 1'b1;
              egr_state_ff <= E_IDLE;
            end
          end
        end
        default: egr_state_ff <= E_IDLE;
      endcase
    end
  end

  assign uplink_rx_control_out = rx_ctl_ff;
  assign uplink_rx_err_out     = rx_err_ff;
  assign uplink_rx_data_out    = rx_dat_ff;

  // clock and media status pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dclk_d_ff  <= 1'b0;
      txclk_ff   <= 1'b0;
      txoe_ff    <= 1'b0;
      rxclk_ff   <= 1'b0;
      rxoe_ff    <= 1'b0;
      col_ff     <= 1'b0;
      crs_ff     <= 1'b0;
      stat_oe_ff <= 1'b0;
    end else begin
      dclk_d_ff  <= div_clk_ff;
      txclk_ff   <= div_clk_ff;
      txoe_ff    <= is_mii && mii_phy_ff;
      rxclk_ff   <= (is_rgmii && dly_egr) ? dclk_d_ff : div_clk_ff;
      rxoe_ff    <= is_rgmii || (is_rmii && rmii_clk) || (is_mii && mii_phy_ff);
      crs_ff     <= is_mii && mii_phy_ff && (en_ff || rx_ctl_ff);
      col_ff     <= is_mii && mii_phy_ff && hdx && en_ff && rx_ctl_ff;
      stat_oe_ff <= is_mii && mii_phy_ff;
    end
  end

  assign uplink_tx_clock_out = txclk_ff;
  assign uplink_tx_clock_oe  = txoe_ff;
  assign uplink_rx_clock_out = rxclk_ff;
  assign uplink_rx_clock_oe  = rxoe_ff;
  assign collision_out       = col_ff;
  assign collision_oe        = stat_oe_ff;
  assign carrier_out         = crs_ff;
  assign carrier_oe          = stat_oe_ff;

  a_ctrl_write: assert property (ctrl_wr |=> ctrl_ff == $past(reg_wdata & CTRL_WMASK))
    else $error("control write not taken");
  a_strap_load: assert property (strap_load && !ctrl_wr |=> ctrl_ff[1:0] == $past(strap_if))
    else $error("strap not loaded into mode field");
  a_rmii_refout: assert property (is_rmii && rmii_clk |=> uplink_rx_clock_oe)
    else $error("reference clock not driven in clock mode");
  a_rmii_toggle: assert property ((is_rmii && rmii_clk)[*3] |-> div_clk_ff != $past(div_clk_ff))
    else $error("reference divider not at half rate");
  a_rsvd_idle: assert property (if_mode == IF_RSVD |=> !uplink_rx_control_out && uplink_rx_data_out == 4'h0)
    else $error("unselected pins active");
  a_rmii_dibit: assert property (is_rmii && egr_stb |=> uplink_rx_data_out[3:2] == 2'b00)
    else $error("upper data lines driven in dibit mode");
  a_col_half: assert property (collision_out |-> $past(hdx) && carrier_out)
    else $error("collision outside half duplex");
  a_sfd_order: assert property ($rose(egr_state_ff == E_DATA) |-> $past(byte_ff) == SFD_BYTE)
    else $error("data started without delimiter");
  a_mac_clkin: assert property (is_mii && !mii_phy_ff |=> !uplink_tx_clock_oe)
    else $error("tx clock driven while facing a phy");
  a_ing_cause: assert property (ing_valid |-> $past(ing_take) && $past(cur_en))
    else $error("byte emitted without a clock edge");

  c_rgmii_frame: cover property (is_rgmii && gbit && egr_state_ff == E_DATA ##1 ing_valid);
  c_rmii_frame: cover property (is_rmii && egr_state_ff == E_DATA);
  c_mii_collision: cover property (is_mii && collision_out);
endmodule
`default_nettype wire

//--- common/upmi_pkg.sv
`default_nettype none
package upmi_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned RMII_REF_HZ   = 50_000_000;
  localparam int unsigned MII_FAST_HZ   = 25_000_000;
  localparam int unsigned MII_SLOW_HZ   = 2_500_000;
  localparam int unsigned RGMII_GIG_HZ  = 125_000_000;
  localparam logic [3:0]  RMII_SLOW_DIV = 4'h9;
  localparam logic [7:0]  CTRL_ADDR     = 8'h56;
  localparam logic [7:0]  PAD_ADDR      = 8'ha4;
  localparam logic [7:0]  CTRL_RST      = 8'h4b;
  localparam logic [7:0]  CTRL_WMASK    = 8'hdb;
  localparam logic [7:0]  PAD_RST       = 8'h00;
  localparam int          IF_SEL_LSB    = 0;
  localparam int          EGR_DLY_BIT   = 3;
  localparam int          ING_DLY_BIT   = 4;
  localparam int          SPEED_BIT     = 6;
  localparam int          RMII_CLK_BIT  = 7;
  localparam logic [7:0]  PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0]  SFD_BYTE      = 8'hd5;
  localparam logic [2:0]  PRE_SFD_IDX   = 3'h6;
  localparam logic [2:0]  PRE_END_IDX   = 3'h7;
  localparam logic [1:0]  UNITS_DIBIT   = 2'h3;
  localparam logic [1:0]  UNITS_NIBBLE  = 2'h1;
  localparam logic [1:0]  STRAP_LOAD_AT = 2'h2;
  localparam int          PIN_W         = 15;

  typedef enum logic [1:0] {
    IF_MII   = 2'b00,
    IF_RMII  = 2'b01,
    IF_RSVD  = 2'b10,
    IF_RGMII = 2'b11
  } upmi_if_t;

  typedef enum logic [1:0] {E_IDLE, E_PRE, E_DATA} upmi_egr_t;

  // half period of a link clock in system clocks, never below one
  function automatic logic [4:0] upmi_half(input int unsigned hz);
    int unsigned h;
    h = CLK_HZ / (2 * hz);
    return (h < 1) ? 5'h01 : h[4:0];
  endfunction

  localparam logic [4:0] HALF_RMII     = upmi_half(RMII_REF_HZ);
  localparam logic [4:0] HALF_MII_FAST = upmi_half(MII_FAST_HZ);
  localparam logic [4:0] HALF_MII_SLOW = upmi_half(MII_SLOW_HZ);
  localparam logic [4:0] HALF_RGMII    = upmi_half(RGMII_GIG_HZ);
endpackage
`default_nettype wire

//--- logic/upmi_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module upmi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    count_ff;
  logic [CW-1:0]    nxt_count;
  logic             ready_ff;
  logic             valid_ff;
  logic             push;
  logic             pop;

  assign push      = in_valid && ready_ff;
  assign pop       = out_ready && valid_ff;
  assign in_ready  = ready_ff;
  assign out_valid = valid_ff;
  assign out_data  = mem_ff[rd_ptr_ff];

  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - CW'(1);
    end
  end

  // ready and valid are registered so both faces come from flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_ff  <= '0;
      ready_ff  <= 1'b1;
      valid_ff  <= 1'b0;
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      count_ff <= nxt_count;
      ready_ff <= nxt_count != CW'(DEPTH);
      valid_ff <= nxt_count != '0;
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

//--- testbench/upmi_partner.sv
`timescale 1ns/1ps
`default_nettype none
module upmi_partner (
  input  wire logic       run,
  input  wire logic       dibit,
  output logic            link_clk,
  output logic            tx_ctl,
  output logic [3:0]      tx_data,
  input  wire logic       rx_ctl,
  input  wire logic [3:0] rx_data
);
  logic [7:0] frame [3] = '{8'h55, 8'hd5, 8'h3c};
  logic [3:0] rx_q [$];
  int         n = 0;
  initial begin
    link_clk = 1'b0;
    tx_ctl = 1'b0;
    tx_data = 4'ha;
  end
  // a new run starts a new frame
  always @(posedge run) begin
    n <= 0;
    rx_q.delete();
  end
  // link clock stands still between transfers, reference in normal mode
  always begin
    wait (run);
    #80 link_clk = ~link_clk;
    if (!run) link_clk = 1'b0;
  end
  // one short frame, low unit first; data moves mid period, so this
  // side carries the ingress clock delay
  always @(negedge link_clk) begin
    if (n < (dibit ? 12 : 6)) begin
      tx_ctl <= 1'b1;
      if (dibit) begin
        tx_data <= {2'b00, 2'(frame[n/4] >> (2 * (n % 4)))};
      end else begin
        tx_data <= n[0] ? frame[n/2][7:4] : frame[n/2][3:0];
      end
    end else begin
      tx_ctl <= 1'b0;
      tx_data <= ~tx_data;
    end
    n <= n + 1;
  end
  // egress nibbles taken on our own clock rise
  always @(posedge link_clk) begin
    if (rx_ctl === 1'b1) rx_q.push_back(rx_data);
  end
endmodule
`default_nettype wire

//--- testbench/uplink_port_media_interface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module uplink_port_media_interface_tb_top;
  import upmi_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} upmi_row_t;
  logic       clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0;
  logic [1:0] s_if = 2'b00;
  logic       s_spd = 1'b1, s_mode = 1'b0, lclk, tctl, rctl, ing_v, ing_s;
  logic       ev = 1'b0, el = 1'b0, erdy;
  logic       dib = 1'b0, rclk, r0, ierr, rerr, rerr_seen = 1'b0, col_o, crs_o;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pad, ing_d, ed = 8'h00;
  logic [3:0] td, rdat;
  wire  [3:0] oes;
  logic [7:0] ing_q [$];
  logic       sof_q [$];
  logic       err_q [$];
  int         mismatches = 0, checked = 0, cycles = 0;
  upmi_row_t  rows [12] = '{'{1'b0,8'h56,8'h00,8'h48}, '{1'b0,8'ha4,8'h00,8'h00},
    '{1'b1,8'h10,8'hff,8'h00}, '{1'b0,8'h10,8'h00,8'h00}, '{1'b1,8'h56,8'hff,8'h00},
    '{1'b0,8'h56,8'h00,8'hdb}, '{1'b1,8'ha4,8'h5a,8'h00}, '{1'b0,8'ha4,8'h00,8'h5a},
    '{1'b1,8'h56,8'h42,8'h00}, '{1'b0,8'h56,8'h00,8'h42},
    '{1'b1,8'h56,8'h48,8'h00}, '{1'b0,8'h56,8'h00,8'h48}};
  upmi_port dut (.clock(clock), .rst(rst), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .uplink_pad_drive(pad), .interface_select_strap(s_if),
    .speed_select_strap(s_spd), .clock_or_phy_mode_strap(s_mode), .half_duplex(1'b0),
    .uplink_tx_clock_in(lclk), .uplink_tx_clock_out(), .uplink_tx_clock_oe(oes[0]),
    .uplink_tx_control_in(tctl), .uplink_tx_err_in(1'b0), .uplink_tx_data_in(td),
    .uplink_rx_clock_in(lclk), .uplink_rx_clock_out(rclk), .uplink_rx_clock_oe(oes[1]),
    .uplink_rx_control_out(rctl), .uplink_rx_err_out(rerr), .uplink_rx_data_out(rdat),
    .collision_in(1'b0), .collision_out(col_o), .collision_oe(oes[2]), .carrier_in(1'b0),
    .carrier_out(crs_o), .carrier_oe(oes[3]), .ing_data(ing_d), .ing_valid(ing_v), .ing_sof(ing_s),
    .ing_err(ierr), .egr_data(ed), .egr_last(el), .egr_valid(ev), .egr_ready(erdy));
  upmi_partner peer (.run(run), .dibit(dib), .link_clk(lclk), .tx_ctl(tctl), .tx_data(td),
    .rx_ctl(rctl), .rx_data(rdat));
  always #5 clock = ~clock;
  task automatic final_report;
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_acc(input upmi_row_t r);
    addr = r.a;
    wdata = r.d;
    wr = r.w;
    rd = ~r.w;
    @(negedge clock);
    wr = 1'b0;
    rd = 1'b0;
    @(negedge clock);
    if (!r.w) cmp("reg_rdata", r.e, rdata);
  endtask
  task automatic frame_run(input logic d);
    int         k;
    logic [7:0] b;
    k = d ? 4 : 2;
    ing_q.delete();
    sof_q.delete();
    err_q.delete();
    dib = d;
    ev = 1'b1;
    ed = 8'haa;
    el = 1'b1;
    @(negedge clock);
    ev = 1'b0;
    run = 1'b1;
    repeat (800) @(negedge clock);
    run = 1'b0;
    repeat (40) @(negedge clock);
    cmp("ing_count", 8'h03, 8'(ing_q.size()));
    for (int i = 0; i < 3 && i < ing_q.size(); i++) begin
      cmp("ing_data", peer.frame[i], ing_q[i]);
      cmp("ing_sof", {7'h0, i == 0}, {7'h0, sof_q[i]});
      cmp("ing_err", 8'h00, {7'h0, err_q[i]});
    end
    cmp("egr_units", 8'(9 * k), 8'(peer.rx_q.size()));
    for (int i = 0; i < 9 * k && i < peer.rx_q.size(); i++) begin
      b = (i / k < 7) ? PREAMBLE_BYTE : ((i / k == 7) ? SFD_BYTE : 8'haa);
      cmp("rx_unit", (b >> ((8 / k) * (i % k))) & (d ? 8'h03 : 8'h0f), {4'h0, peer.rx_q[i]});
    end
    cmp("rx_err", 8'h00, {7'h0, rerr_seen});
  endtask
  always @(negedge clock) begin
    if (ing_v === 1'b1) begin
      ing_q.push_back(ing_d);
      sof_q.push_back(ing_s);
      err_q.push_back(ierr);
    end
    if (rerr === 1'b1) begin
      rerr_seen = 1'b1;
    end
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    repeat (5) @(negedge clock);
    foreach (rows[i]) reg_acc(rows[i]);
    cmp("pad_drive", 8'h5a, pad);
    cmp("oe_mac_mode", 8'h00, {4'h0, oes});
    cmp("egr_ready", 8'h01, {7'h0, erdy});
    cmp("col_crs_mac", 8'h00, {6'h0, col_o, crs_o});
    frame_run(1'b0);
    s_spd = 1'b0;
    rst = 1'b1;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    repeat (5) @(negedge clock);
    reg_acc('{1'b0, 8'h56, 8'h00, 8'h08});
    reg_acc('{1'b1, 8'h56, 8'h41, 8'h00});
    cmp("oe_rmii_normal", 8'h00, {4'h0, oes});
    frame_run(1'b1);
    reg_acc('{1'b1, 8'h56, 8'hc1, 8'h00});
    cmp("oe_rmii_clock", 8'h02, {4'h0, oes});
    r0 = rclk;
    @(negedge clock);
    cmp("ref_clock_toggle", {7'h0, ~r0}, {7'h0, rclk});
    final_report();
  end
endmodule
`default_nettype wire
